// ---- core/shc_pkg.sv ----
// Shared constants and types of the standby and halt control block.
package shc_pkg;
  // Register indices on the device link.
  localparam logic [1:0] IDX_CONTROL = 2'h0;
  localparam logic [1:0] IDX_MODE    = 2'h1;
  localparam logic [1:0] IDX_SETTLE  = 2'h2;
  // Standby control field positions and masks.
  localparam int         BIT_ENTRY       = 1;
  localparam int         BIT_MASKABLE_WAKE_MASK        = 4;
  localparam int         BIT_NMIM        = 5;
  localparam int         BIT_WD2M        = 6;
  localparam logic [7:0] CTRL_WMASK      = 8'h72;
  localparam logic [7:0] CTRL_WAKE_MASKS = 8'h70;
  localparam logic [7:0] CTRL_ENTRY      = 8'h02;
  // Standby mode select field positions and masks.
  localparam int         BIT_PSM    = 0;
  localparam int         BIT_SUBCLOCK_DISABLE_BIT  = 7;
  localparam logic [7:0] MODE_WMASK = 8'h81;
  localparam logic [7:0] MODE_SUBCLOCK_DISABLE_BIT = 8'h80;
  // Oscillation settle select field.
  localparam int         SETTLE_SEL_W = 3;
  localparam logic [7:0] SETTLE_WMASK = 8'h07;
  // Reset values.
  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [7:0] MODE_RESET   = 8'h00;
  localparam logic [7:0] SETTLE_RESET = 8'h01;
  // Settle exponents for codes 7 down to 0, five bits each.
  localparam int          EXP_W  = 5;
  localparam int          CNT_W  = 22;
  localparam int          EXP_MAX = 21;
  localparam logic [39:0] SETTLE_EXP_DEFAULT = {5'h15, 5'h14, 5'h13, 5'h12,
                                                5'h11, 5'h10, 5'h0F, 5'h0D};
  // Instruction slots the CPU side idles after a halt.
  localparam logic [2:0] NOP_COUNT = 3'h5;
  // APB offsets of the CPU side.
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_MODE   = 8'h04;
  localparam logic [7:0] ADDR_SETTLE = 8'h08;
  localparam logic [7:0] ADDR_CMD    = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  // Command job bits.
  localparam int JOB_MODE   = 0;
  localparam int JOB_SETTLE = 1;
  localparam int JOB_CTRL   = 2;
  localparam int JOB_HALT   = 3;
  localparam int JOB_READ   = 4;
  localparam int JOB_W      = 5;
  localparam int CMD_IDX_LSB = 8;

  typedef enum logic [1:0] {
    ST_RUN     = 2'b00,
    ST_STANDBY = 2'b01,
    ST_SETTLE  = 2'b11,
    ST_HALT    = 2'b10
  } shc_state_type;

  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_KEY  = 2'b01,
    HS_CTRL = 2'b11,
    HS_NOP  = 2'b10
  } shc_host_type;
endpackage

// ---- core/shc_if.sv ----
// Link between the CPU side and the standby controller.
`timescale 1ns/100ps
interface shc_if;
  logic                  reg_wr;
  logic                  reg_rd;
  logic                  prot_wr;
  logic [1:0]            reg_idx;
  logic [7:0]            reg_wdata;
  logic [7:0]            reg_rdata;
  logic                  halt_exec;
  logic                  nmi_pin;
  logic                  wdog1_nmi_request;
  logic                  wdog2_nmi_request;
  logic                  wdog1_reset_request;
  logic                  wdog2_reset_request;
  logic                  irq_pending;
  logic                  irq_higher;
  shc_pkg::shc_state_type dev_state;
  logic                  irq_accept;
  logic                  irq_hold;

  modport dev (
    input  reg_wr, reg_rd, prot_wr, reg_idx, reg_wdata, halt_exec,
    input  nmi_pin, wdog1_nmi_request, wdog2_nmi_request,
    input  wdog1_reset_request, wdog2_reset_request, irq_pending, irq_higher,
    output reg_rdata, dev_state, irq_accept, irq_hold
  );

  modport cpu (
    output reg_wr, reg_rd, prot_wr, reg_idx, reg_wdata, halt_exec,
    output nmi_pin, wdog1_nmi_request, wdog2_nmi_request,
    output wdog1_reset_request, wdog2_reset_request, irq_pending, irq_higher,
    input  reg_rdata, dev_state, irq_accept, irq_hold
  );
endinterface

// ---- core/shc_standby_ctrl.sv ----
// Standby and halt controller: registers, mode machine and settle counter.
`timescale 1ns/100ps
// What this block does
// - Control register writable only after protect write.
// - Watchdog-2 interrupt wakes standby unless masked.
// - NMI pin wakes standby unless masked.
// - Maskable interrupts wake standby unless masked.
// - Entry bit one enters IDLE or STOP.
// - Masks written with entry bit are discarded.
// - Software masks pending sources in earlier write.
// - Software writes mode select before entry.
// - Select bit: zero IDLE, one STOP.
// - Subclock used when disable bit is zero.
// - Mode select bits one to six written zero.
// - Settle code picks two-power wait length.
// - Settle select bits three to seven zero.
// - Reset release waits two to fifteen.
// - Settle count starts once oscillator runs.
// - Settle wait applies to external clock too.
// - Halt instruction enters HALT from normal.
// - HALT gates only the CPU clock.
// - HALT stops execution, RAM keeps contents.
// - Software follows halt with five idle slots.
// - Pending request at halt releases at once.
// - NMI, watchdogs, interrupts or resets end HALT.
// - Lower priority wakes only; higher is acknowledged.
module shc_standby_ctrl #(
  parameter logic [39:0] SETTLE_EXP = shc_pkg::SETTLE_EXP_DEFAULT
) (
  // Clock and reset
  input  logic  pclk,
  input  logic  presetn,
  // Link to the CPU side
  shc_if.dev    link,
  // Oscillator status
  input  logic  osc_running,
  // Clock and retention controls
  output logic  cpu_clk_en,
  output logic  periph_clk_en,
  output logic  osc_enable,
  output logic  subclock_osc_en,
  output logic  ram_retain
);

  generate
    for (genvar g = 0; g < 8; g++) begin : g_exp_check
      if (SETTLE_EXP[g*shc_pkg::EXP_W +: shc_pkg::EXP_W] > shc_pkg::EXP_MAX ||
          SETTLE_EXP[g*shc_pkg::EXP_W +: shc_pkg::EXP_W] == 0) begin : g_bad
        $error("Settle exponent out of range.");
      end
    end
  endgenerate

  localparam logic [shc_pkg::CNT_W-1:0] CNT_ONE = 22'h000001;

  shc_pkg::shc_state_type      state_reg;
  shc_pkg::shc_state_type      state_next;
  logic [7:0]                  ctrl_reg;
  logic [7:0]                  mode_reg;
  logic [7:0]                  settle_reg;
  logic                        prot_armed_reg;
  logic [shc_pkg::CNT_W-1:0]   cnt_reg;
  logic                        cpu_clk_en_reg;
  logic                        irq_accept_reg;
  logic                        irq_hold_reg;
  logic [7:0]                  rdata_reg;

  // The settle length is looked up rather than stored so that a late
  // settle select write still governs a wait already under way.
  function automatic logic [shc_pkg::CNT_W-1:0] settle_last(
    input logic [shc_pkg::SETTLE_SEL_W-1:0] code
  );
    logic [shc_pkg::EXP_W-1:0] e;
    e = SETTLE_EXP[code*shc_pkg::EXP_W +: shc_pkg::EXP_W];
    settle_last = (CNT_ONE << e) - CNT_ONE;
  endfunction

  // Register access decode.
  wire       wdog_reset  = link.wdog1_reset_request | link.wdog2_reset_request;
  wire       ctrl_wr     = link.reg_wr & prot_armed_reg &
                           (link.reg_idx == shc_pkg::IDX_CONTROL);
  wire       mode_wr     = link.reg_wr & (link.reg_idx == shc_pkg::IDX_MODE);
  wire       settle_wr   = link.reg_wr & (link.reg_idx == shc_pkg::IDX_SETTLE);
  wire [7:0] ctrl_wval   = link.reg_wdata & shc_pkg::CTRL_WMASK;
  wire       entry_req   = ctrl_wval[shc_pkg::BIT_ENTRY];
  wire [7:0] ctrl_kept   = entry_req ?
                           ((ctrl_reg & shc_pkg::CTRL_WAKE_MASKS) | shc_pkg::CTRL_ENTRY) :
                           ctrl_wval;
  wire       prot_next   = link.prot_wr ? 1'b1 : (link.reg_wr ? 1'b0 : prot_armed_reg);

  // Wake sources.
  wire wake_wd2     = link.wdog2_nmi_request & ~ctrl_reg[shc_pkg::BIT_WD2M];
  wire wake_nmi     = link.nmi_pin & ~ctrl_reg[shc_pkg::BIT_NMIM];
  wire wake_irq     = link.irq_pending & ~ctrl_reg[shc_pkg::BIT_MASKABLE_WAKE_MASK];
  wire standby_wake = wake_wd2 | wake_nmi | wake_irq;
  wire nmi_any      = link.nmi_pin | link.wdog1_nmi_request | link.wdog2_nmi_request;
  wire halt_wake    = nmi_any | link.irq_pending;
  wire stop_sel     = mode_reg[shc_pkg::BIT_PSM];

  wire [shc_pkg::SETTLE_SEL_W-1:0] settle_code = settle_reg[shc_pkg::SETTLE_SEL_W-1:0];
  wire settle_done = (cnt_reg == settle_last(settle_code));

  // Standby release clears the entry bit so the CPU resumes in normal mode.
  wire       leave_sb  = (state_reg == shc_pkg::ST_STANDBY) &
                         (state_next != shc_pkg::ST_STANDBY);
  wire [7:0] ctrl_next = ctrl_wr ? ctrl_kept :
                         (leave_sb ? (ctrl_reg & ~shc_pkg::CTRL_ENTRY) : ctrl_reg);
  wire [7:0] mode_next = mode_wr ? (link.reg_wdata & shc_pkg::MODE_WMASK) : mode_reg;
  wire [7:0] settle_next = settle_wr ? (link.reg_wdata & shc_pkg::SETTLE_WMASK) :
                           settle_reg;

  // Counting waits for the oscillator to run, and an external clock source
  // gets the same wait because nothing here can tell the two apart.
  wire [shc_pkg::CNT_W-1:0] cnt_next =
    (state_reg != shc_pkg::ST_SETTLE) ? '0 :
    (osc_running ? (cnt_reg + CNT_ONE) : cnt_reg);

  wire halt_release   = (state_reg == shc_pkg::ST_HALT) & halt_wake;
  wire accept_next    = halt_release & (nmi_any | link.irq_higher);
  wire hold_next      = halt_release & ~nmi_any & ~link.irq_higher;

  wire [7:0] rd_mux   = (link.reg_idx == shc_pkg::IDX_CONTROL) ? ctrl_reg :
                        (link.reg_idx == shc_pkg::IDX_MODE)    ? mode_reg :
                        (link.reg_idx == shc_pkg::IDX_SETTLE)  ? settle_reg : 8'h00;
  wire [7:0] rdata_next = link.reg_rd ? rd_mux : rdata_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      shc_pkg::ST_RUN: begin
        if (ctrl_wr && entry_req) begin
          state_next = shc_pkg::ST_STANDBY;
        end else if (link.halt_exec) begin
          state_next = shc_pkg::ST_HALT;
        end
      end
      shc_pkg::ST_HALT: begin
        if (halt_wake) begin
          state_next = shc_pkg::ST_RUN;
        end
      end
      shc_pkg::ST_STANDBY: begin
        if (standby_wake) begin
          state_next = stop_sel ? shc_pkg::ST_SETTLE : shc_pkg::ST_RUN;
        end
      end
      shc_pkg::ST_SETTLE: begin
        if (osc_running && settle_done) begin
          state_next = shc_pkg::ST_RUN;
        end
      end
      default: begin
        state_next = shc_pkg::ST_RUN;
      end
    endcase
  end

  // Reset enters the settle wait with the reset settle code.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg      <= shc_pkg::ST_SETTLE;
      ctrl_reg       <= shc_pkg::CTRL_RESET;
      mode_reg       <= shc_pkg::MODE_RESET;
      settle_reg     <= shc_pkg::SETTLE_RESET;
      prot_armed_reg <= 1'b0;
      cnt_reg        <= '0;
    end else if (wdog_reset) begin
      state_reg      <= shc_pkg::ST_SETTLE;
      ctrl_reg       <= shc_pkg::CTRL_RESET;
      mode_reg       <= shc_pkg::MODE_RESET;
      settle_reg     <= shc_pkg::SETTLE_RESET;
      prot_armed_reg <= 1'b0;
      cnt_reg        <= '0;
    end else begin
      state_reg      <= state_next;
      ctrl_reg       <= ctrl_next;
      mode_reg       <= mode_next;
      settle_reg     <= settle_next;
      prot_armed_reg <= prot_next;
      cnt_reg        <= cnt_next;
    end
  end

  // The gate enable is a flop so the clock gate only sees edge-aligned changes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_clk_en_reg <= 1'b0;
      irq_accept_reg <= 1'b0;
      irq_hold_reg   <= 1'b0;
      rdata_reg      <= 8'h00;
    end else begin
      cpu_clk_en_reg <= (state_next == shc_pkg::ST_RUN) & ~wdog_reset;
      irq_accept_reg <= accept_next & ~wdog_reset;
      irq_hold_reg   <= hold_next & ~wdog_reset;
      rdata_reg      <= rdata_next;
    end
  end

  assign cpu_clk_en      = cpu_clk_en_reg;
  assign periph_clk_en   = (state_reg != shc_pkg::ST_STANDBY);
  assign osc_enable      = ~((state_reg == shc_pkg::ST_STANDBY) & stop_sel);
  assign subclock_osc_en = ~mode_reg[shc_pkg::BIT_SUBCLOCK_DISABLE_BIT];
  assign ram_retain      = (state_reg != shc_pkg::ST_RUN);
  assign link.reg_rdata  = rdata_reg;
  assign link.dev_state  = state_reg;
  assign link.irq_accept = irq_accept_reg;
  assign link.irq_hold   = irq_hold_reg;

endmodule

// ---- core/shc_cpu_side.sv ----
// CPU side: APB command registers and protected write sequencer.
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/100ps
module shc_cpu_side (
  // Clock and reset
  input  logic        pclk,
  input  logic        presetn,
  // APB slave
  input  logic        psel,
  input  logic        penable,
  input  logic        pwrite,
  input  logic [7:0]  paddr,
  input  logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  // Wake and reset sources
  input  logic        nmi_pin,
  input  logic        wdog1_nmi_request,
  input  logic        wdog2_nmi_request,
  input  logic        wdog1_reset_request,
  input  logic        wdog2_reset_request,
  input  logic        irq_pending,
  input  logic        irq_higher,
  // Board strap
  input  logic        resonator_present,
  // Link to the standby controller
  shc_if.cpu          link
);

  shc_pkg::shc_host_type     hs_reg;
  shc_pkg::shc_host_type     hs_next;
  logic [7:0]                sh_ctrl_reg;
  logic [7:0]                sh_mode_reg;
  logic [7:0]                sh_settle_reg;
  logic [shc_pkg::JOB_W-1:0] job_reg;
  logic [shc_pkg::JOB_W-1:0] job_clr;
  logic [1:0]                rd_idx_reg;
  logic [7:0]                readback_reg;
  logic                      rd_pend_reg;
  logic                      split_reg;
  logic                      split_next;
  logic [2:0]                nop_reg;
  logic [2:0]                nop_next;
  logic                      wr_reg, wr_next;
  logic                      rd_reg, rd_next;
  logic                      key_reg, key_next;
  logic                      halt_reg, halt_next;
  logic [1:0]                idx_reg, idx_next;
  logic [7:0]                wd_reg, wd_next;
  logic [31:0]               prdata_reg;

  // APB decode; every access finishes in its first access cycle.
  wire apb_wr   = psel & penable & pwrite;
  wire apb_rs   = psel & ~penable & ~pwrite;
  wire mapped   = (paddr == shc_pkg::ADDR_CTRL) | (paddr == shc_pkg::ADDR_MODE) |
                  (paddr == shc_pkg::ADDR_SETTLE) | (paddr == shc_pkg::ADDR_CMD) |
                  (paddr == shc_pkg::ADDR_STATUS);
  wire cmd_wr   = apb_wr & (paddr == shc_pkg::ADDR_CMD);
  wire [shc_pkg::JOB_W-1:0] cmd_jobs = pwdata[shc_pkg::JOB_W-1:0];
  wire entry_sh = sh_ctrl_reg[shc_pkg::BIT_ENTRY];
  // An entry request drags a mode select write in ahead of it.
  wire [shc_pkg::JOB_W-1:0] job_set = cmd_wr ?
    (cmd_jobs | {{(shc_pkg::JOB_W-1){1'b0}}, cmd_jobs[shc_pkg::JOB_CTRL] & entry_sh}) :
    '0;
  wire [shc_pkg::JOB_W-1:0] job_next = (job_reg & ~job_clr) | job_set;
  wire busy     = (hs_reg != shc_pkg::HS_IDLE) | (job_reg != '0);

  // Reserved bits are forced low, and a fitted resonator keeps the subclock.
  wire [7:0] mode_val = sh_mode_reg & shc_pkg::MODE_WMASK &
                        ~(resonator_present ? shc_pkg::MODE_SUBCLOCK_DISABLE_BIT : 8'h00);
  wire [7:0] settle_val = sh_settle_reg & shc_pkg::SETTLE_WMASK;
  wire [7:0] ctrl_val   = sh_ctrl_reg & shc_pkg::CTRL_WMASK;
  wire       need_split = entry_sh & ((ctrl_val & shc_pkg::CTRL_WAKE_MASKS) != 8'h00);

  wire [31:0] status_val = {16'h0000, readback_reg, 3'h0, link.irq_hold,
                            link.irq_accept, link.dev_state, busy};
  wire [31:0] rd_mux = (paddr == shc_pkg::ADDR_CTRL)   ? {24'h000000, sh_ctrl_reg} :
                       (paddr == shc_pkg::ADDR_MODE)   ? {24'h000000, sh_mode_reg} :
                       (paddr == shc_pkg::ADDR_SETTLE) ? {24'h000000, sh_settle_reg} :
                       (paddr == shc_pkg::ADDR_STATUS) ? status_val : 32'h00000000;

  always_comb begin
    hs_next    = hs_reg;
    job_clr    = '0;
    split_next = split_reg;
    nop_next   = nop_reg;
    wr_next    = 1'b0;
    rd_next    = 1'b0;
    key_next   = 1'b0;
    halt_next  = 1'b0;
    idx_next   = idx_reg;
    wd_next    = wd_reg;
    case (hs_reg)
      shc_pkg::HS_IDLE: begin
        if (job_reg[shc_pkg::JOB_MODE]) begin
          wr_next  = 1'b1;
          idx_next = shc_pkg::IDX_MODE;
          wd_next  = mode_val;
          job_clr[shc_pkg::JOB_MODE] = 1'b1;
        end else if (job_reg[shc_pkg::JOB_SETTLE]) begin
          wr_next  = 1'b1;
          idx_next = shc_pkg::IDX_SETTLE;
          wd_next  = settle_val;
          job_clr[shc_pkg::JOB_SETTLE] = 1'b1;
        end else if (job_reg[shc_pkg::JOB_CTRL]) begin
          key_next   = 1'b1;
          split_next = need_split;
          hs_next    = shc_pkg::HS_KEY;
        end else if (job_reg[shc_pkg::JOB_HALT]) begin
          halt_next = 1'b1;
          nop_next  = shc_pkg::NOP_COUNT - 3'h1;
          hs_next   = shc_pkg::HS_NOP;
          job_clr[shc_pkg::JOB_HALT] = 1'b1;
        end else if (job_reg[shc_pkg::JOB_READ]) begin
          rd_next  = 1'b1;
          idx_next = rd_idx_reg;
          job_clr[shc_pkg::JOB_READ] = 1'b1;
        end
      end
      shc_pkg::HS_KEY: begin
        wr_next  = 1'b1;
        idx_next = shc_pkg::IDX_CONTROL;
        wd_next  = split_reg ? (ctrl_val & ~shc_pkg::CTRL_ENTRY) : ctrl_val;
        hs_next  = shc_pkg::HS_CTRL;
      end
      shc_pkg::HS_CTRL: begin
        if (split_reg) begin
          split_next = 1'b0;
          key_next   = 1'b1;
          hs_next    = shc_pkg::HS_KEY;
        end else begin
          job_clr[shc_pkg::JOB_CTRL] = 1'b1;
          hs_next = shc_pkg::HS_IDLE;
        end
      end
      shc_pkg::HS_NOP: begin
        if (nop_reg == 3'h0) begin
          hs_next = shc_pkg::HS_IDLE;
        end else begin
          nop_next = nop_reg - 3'h1;
        end
      end
      default: begin
        hs_next = shc_pkg::HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_reg        <= shc_pkg::HS_IDLE;
      job_reg       <= '0;
      split_reg     <= 1'b0;
      nop_reg       <= 3'h0;
      {wr_reg, rd_reg, key_reg, halt_reg} <= 4'h0;
      idx_reg       <= 2'h0;
      wd_reg        <= 8'h00;
      rd_pend_reg   <= 1'b0;
    end else begin
      hs_reg        <= hs_next;
      job_reg       <= job_next;
      split_reg     <= split_next;
      nop_reg       <= nop_next;
      {wr_reg, rd_reg, key_reg, halt_reg} <= {wr_next, rd_next, key_next, halt_next};
      idx_reg       <= idx_next;
      wd_reg        <= wd_next;
      rd_pend_reg   <= rd_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_ctrl_reg   <= shc_pkg::CTRL_RESET;
      sh_mode_reg   <= shc_pkg::MODE_RESET;
      sh_settle_reg <= shc_pkg::SETTLE_RESET;
      rd_idx_reg    <= 2'h0;
      readback_reg  <= 8'h00;
      prdata_reg    <= 32'h00000000;
    end else begin
      if (apb_wr && paddr == shc_pkg::ADDR_CTRL) sh_ctrl_reg <= pwdata[7:0];
      if (apb_wr && paddr == shc_pkg::ADDR_MODE) sh_mode_reg <= pwdata[7:0];
      if (apb_wr && paddr == shc_pkg::ADDR_SETTLE) sh_settle_reg <= pwdata[7:0];
      if (cmd_wr) rd_idx_reg <= pwdata[shc_pkg::CMD_IDX_LSB +: 2];
      if (rd_pend_reg) readback_reg <= link.reg_rdata;
      if (apb_rs) prdata_reg <= rd_mux;
    end
  end

  assign prdata   = prdata_reg;
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~mapped;

  assign link.reg_wr    = wr_reg;
  assign link.reg_rd    = rd_reg;
  assign link.prot_wr   = key_reg;
  assign link.halt_exec = halt_reg;
  assign link.reg_idx   = idx_reg;
  assign link.reg_wdata = wd_reg;
  assign link.nmi_pin             = nmi_pin;
  assign link.wdog1_nmi_request   = wdog1_nmi_request;
  assign link.wdog2_nmi_request   = wdog2_nmi_request;
  assign link.wdog1_reset_request = wdog1_reset_request;
  assign link.wdog2_reset_request = wdog2_reset_request;
  assign link.irq_pending         = irq_pending;
  assign link.irq_higher          = irq_higher;

endmodule

// ---- sim/shc_link_properties.sv ----
// Concurrent checks on the link between the CPU side and the standby controller.
`timescale 1ns/100ps
module shc_link_properties #(
  parameter logic [39:0] SETTLE_EXP = shc_pkg::SETTLE_EXP_DEFAULT
) (
  // Clock and reset
  input logic                   pclk,
  input logic                   presetn,
  // Link
  input logic                   reg_wr,
  input logic                   prot_wr,
  input logic [1:0]             reg_idx,
  input logic [7:0]             reg_wdata,
  input logic                   halt_exec,
  input logic                   nmi_pin,
  input logic                   wdog1_nmi_request,
  input logic                   wdog2_nmi_request,
  input logic                   wdog1_reset_request,
  input logic                   wdog2_reset_request,
  input logic                   irq_pending,
  input logic                   irq_higher,
  input shc_pkg::shc_state_type dev_state,
  input logic                   irq_accept,
  input logic                   irq_hold,
  // Device status
  input logic                   cpu_clk_en,
  input logic                   periph_clk_en,
  input logic                   osc_running
);
  logic [2:0]  code_reg;
  logic [22:0] cnt_reg;
  wire         wdrst = wdog1_reset_request | wdog2_reset_request;
  wire         nmi = nmi_pin | wdog1_nmi_request | wdog2_nmi_request;
  wire         wake = nmi | irq_pending;
  wire         in_set = dev_state == shc_pkg::ST_SETTLE;
  wire [4:0]   exp_w = SETTLE_EXP[code_reg*5 +: 5];
  wire         set_wr = reg_wr && reg_idx == shc_pkg::IDX_SETTLE;
  // The counter holds while the oscillator is not yet running.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_reg <= 3'h1;
      cnt_reg  <= 23'h0;
    end else begin
      code_reg <= wdrst ? 3'h1 : (set_wr ? reg_wdata[2:0] : code_reg);
      cnt_reg  <= (wdrst || !in_set) ? 23'h0 : cnt_reg + {22'h0, osc_running};
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_prot_entry;
    prot_wr ##1 (reg_wr && reg_idx == shc_pkg::IDX_CONTROL && reg_wdata[shc_pkg::BIT_ENTRY]
      && dev_state == shc_pkg::ST_RUN && !wdrst);
  endsequence
  a_entry_standby: assert property (s_prot_entry |=> dev_state == shc_pkg::ST_STANDBY)
    else $error("standby not entered");
  a_ctrl_protected: assert property (reg_wr && reg_idx == shc_pkg::IDX_CONTROL |-> $past(prot_wr))
    else $error("control write without protect step");
  a_halt_entry: assert property (halt_exec && dev_state == shc_pkg::ST_RUN && !wdrst
    |=> dev_state == shc_pkg::ST_HALT) else $error("halt not entered");
  a_halt_release: assert property (dev_state == shc_pkg::ST_HALT && !wdrst
    |=> dev_state == ($past(wake) ? shc_pkg::ST_RUN : shc_pkg::ST_HALT)) else $error("halt exit");
  a_gate_state: assert property (cpu_clk_en == (dev_state == shc_pkg::ST_RUN))
    else $error("cpu clock gate wrong");
  a_halt_periph: assert property (dev_state == shc_pkg::ST_HALT |-> periph_clk_en)
    else $error("peripheral clock stopped in halt");
  a_standby_hold: assert property (dev_state == shc_pkg::ST_STANDBY && !wake && !wdrst
    |=> dev_state == shc_pkg::ST_STANDBY) else $error("standby left without wake");
  a_halt_priority: assert property (dev_state == shc_pkg::ST_HALT && irq_pending && !nmi
    && !wdrst |=> irq_accept == $past(irq_higher) && irq_hold == !$past(irq_higher))
    else $error("halt release priority wrong");
  a_settle_len: assert property (dev_state == shc_pkg::ST_RUN && $past(in_set)
    |-> cnt_reg == (23'h1 << exp_w)) else $error("settle wait length wrong");
  a_wdog_reset: assert property (wdrst |=> in_set && !cpu_clk_en)
    else $error("watchdog reset ignored");
endmodule

// ---- sim/tb_standby_halt_control.sv ----
// Bench driving both ends of the standby link through the APB command port.
`timescale 1ns/100ps
module tb_standby_halt_control;
  localparam logic [39:0] EXP = {5'h06, 5'h06, 5'h06, 5'h06, 5'h05, 5'h05, 5'h04, 5'h03};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
  logic        nmi, wd1n, wd2n, wd1r, wd2r, irqp, irqh, reso, osc_running, osc_en;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdata;
  int          err_total, n_compared;
  shc_if u_shc_if();
  shc_standby_ctrl #(.SETTLE_EXP(EXP)) u_shc_standby_ctrl (.pclk(pclk), .presetn(presetn),
    .link(u_shc_if.dev), .osc_running(osc_running), .cpu_clk_en(), .periph_clk_en(),
    .osc_enable(osc_en), .subclock_osc_en(), .ram_retain());
  shc_cpu_side u_shc_cpu_side (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .nmi_pin(nmi), .wdog1_nmi_request(wd1n), .wdog2_nmi_request(wd2n),
    .wdog1_reset_request(wd1r), .wdog2_reset_request(wd2r), .irq_pending(irqp),
    .irq_higher(irqh), .resonator_present(reso), .link(u_shc_if.cpu));
  shc_link_properties #(.SETTLE_EXP(EXP)) u_props (.pclk(pclk), .presetn(presetn),
    .reg_wr(u_shc_if.reg_wr), .prot_wr(u_shc_if.prot_wr), .reg_idx(u_shc_if.reg_idx),
    .reg_wdata(u_shc_if.reg_wdata), .halt_exec(u_shc_if.halt_exec), .nmi_pin(u_shc_if.nmi_pin),
    .wdog1_nmi_request(u_shc_if.wdog1_nmi_request), .wdog2_nmi_request(u_shc_if.wdog2_nmi_request),
    .wdog1_reset_request(u_shc_if.wdog1_reset_request),
    .wdog2_reset_request(u_shc_if.wdog2_reset_request), .irq_pending(u_shc_if.irq_pending),
    .irq_higher(u_shc_if.irq_higher), .dev_state(u_shc_if.dev_state),
    .irq_accept(u_shc_if.irq_accept), .irq_hold(u_shc_if.irq_hold),
    .cpu_clk_en(u_shc_standby_ctrl.cpu_clk_en), .periph_clk_en(u_shc_standby_ctrl.periph_clk_en),
    .osc_running(osc_running));
  // The oscillator starts one cycle after it is enabled, so settle counting must wait for it.
  always @(posedge pclk) osc_running <= osc_en;
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [31:0] v);
    apb(1'b1, shc_pkg::ADDR_CMD, v);
    do apb(1'b0, shc_pkg::ADDR_STATUS, 32'h0); while (rdata[0] !== 1'b0);
  endtask
  task automatic wait_st(input logic [1:0] st);
    do apb(1'b0, shc_pkg::ADDR_STATUS, 32'h0); while (rdata[2:1] !== st);
  endtask
  task automatic rdev(input logic [1:0] idx, input logic [7:0] exp);
    cmd(32'h10 | ({30'h0, idx} << 8));
    apb(1'b0, shc_pkg::ADDR_STATUS, 32'h0);
    chk(rdata[15:8], exp);
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #(40 * 40000);
    err_total++;
    end_of_test();
  end
  initial begin
    {psel, penable, pwrite, nmi, wd1n, wd2n, wd1r, wd2r, irqp, irqh, reso} = 11'h000;
    {paddr, pwdata, presetn, osc_running, err_total, n_compared} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    wait_st(shc_pkg::ST_RUN);
    rdev(2'h0, 8'h00);
    rdev(2'h1, 8'h00);
    rdev(2'h2, 8'h01);
    apb(1'b0, 8'h14, 32'h0);
    chk(serr, 1'b1);
    apb(1'b1, shc_pkg::ADDR_MODE, 32'h80);
    cmd(32'h1);
    rdev(2'h1, 8'h80);
    reso <= 1'b1;
    cmd(32'h1);
    rdev(2'h1, 8'h00);
    $display("test registers done");
    cmd(32'h8);
    wait_st(shc_pkg::ST_HALT);
    irqp <= 1'b1;
    wait_st(shc_pkg::ST_RUN);
    irqh <= 1'b1;
    cmd(32'h8);
    wait_st(shc_pkg::ST_RUN);
    {irqp, irqh} <= 2'h0;
    $display("test halt done");
    apb(1'b1, shc_pkg::ADDR_MODE, 32'h0);
    apb(1'b1, shc_pkg::ADDR_CTRL, 32'h12);
    cmd(32'h4);
    wait_st(shc_pkg::ST_STANDBY);
    irqp <= 1'b1;
    repeat (20) apb(1'b0, shc_pkg::ADDR_STATUS, 32'h0);
    chk(rdata[2:1], shc_pkg::ST_STANDBY);
    nmi <= 1'b1;
    wait_st(shc_pkg::ST_RUN);
    {nmi, irqp} <= 2'h0;
    rdev(2'h0, 8'h10);
    $display("test idle done");
    apb(1'b1, shc_pkg::ADDR_SETTLE, 32'h0);
    apb(1'b1, shc_pkg::ADDR_MODE, 32'h1);
    apb(1'b1, shc_pkg::ADDR_CTRL, 32'h32);
    cmd(32'h7);
    wait_st(shc_pkg::ST_STANDBY);
    rdev(2'h0, 8'h32);
    wd2n <= 1'b1;
    wait_st(shc_pkg::ST_RUN);
    rdev(2'h2, 8'h00);
    {wd1r, wd2n} <= 2'b10;
    @(posedge pclk);
    wd1r <= 1'b0;
    wait_st(shc_pkg::ST_RUN);
    rdev(2'h2, 8'h01);
    $display("test stop done");
    end_of_test();
  end
endmodule
